// ==== incr_or_move_instr_exec_tb.sv ====
// self-checking bench for the increment / or / move execution block
`timescale 1ns/1ps
`default_nettype none
module incr_or_move_instr_exec_tb;
  import ioxe_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic vld = 1'b0;
  logic [IW-1:0] instr = '0;
  logic [DW-1:0] rdata = '0;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] acc;
  logic we;
  logic zf;
  logic skip;
  logic hnd;
  int num_errors = 0;
  int n_tests = 0;
  ioxe_exec ioxe_exec_inst (.CLK_I(clk), .RST_B_I(rst_b), .INSTR_VALID_I(vld),
    .INSTR_I(instr), .FILE_RDATA_I(rdata), .FILE_ADDR_O(addr), .FILE_WDATA_O(wdata),
    .FILE_WE_O(we), .ACC_O(acc), .ZERO_FLAG_O(zf), .SKIP_O(skip), .HANDLED_O(hnd));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task ck(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : ck
  task post(input logic [7:0] a, input logic z, input logic w, input logic [7:0] wd);
    ck("acc", a, acc);
    ck("zero", z, zf);
    ck("we", w, we);
    if (w)
      ck("wdata", wd, wdata);
  endtask : post
  // one word offered for one cycle, handled and addr checked before its edge, registered outputs after it
  task issue(input logic [IW-1:0] w, input logic [7:0] rd, input logic h);
    @(posedge clk);
    vld <= 1'b1;
    instr <= w;
    rdata <= rd;
    #1;
    ck("handled", h, hnd);
    if (h)
      ck("addr", w[6:0], addr);
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask : issue
  task t_copy;
    issue({OPC_COPY_FILE, 1'b0, 7'h7f}, 8'h00, 1'b1);
    post(8'h00, 1'b1, 1'b0, 8'h00);
    issue({OPC_COPY_FILE, 1'b1, 7'h11}, 8'h5a, 1'b1);
    post(8'h00, 1'b0, 1'b1, 8'h5a);
  endtask : t_copy
  task t_load;
    issue({OPC_COPY_FILE, 1'b0, 7'h00}, 8'h00, 1'b1);
    issue({OPC_LOAD_LIT, 2'b11, 8'h55}, 8'h00, 1'b1);
    post(8'h55, 1'b1, 1'b0, 8'h00);
  endtask : t_load
  task t_inc;
    issue({OPC_INC_FILE, 1'b0, 7'h7f}, 8'hff, 1'b1);
    post(8'h00, 1'b1, 1'b0, 8'h00);
    issue({OPC_INC_FILE, 1'b1, 7'h05}, 8'h41, 1'b1);
    post(8'h00, 1'b0, 1'b1, 8'h42);
  endtask : t_inc
  task t_or;
    issue({OPC_OR_LIT, 8'h00}, 8'h00, 1'b1);
    post(8'h00, 1'b1, 1'b0, 8'h00);
    issue({OPC_OR_LIT, 8'h81}, 8'h00, 1'b1);
    post(8'h81, 1'b0, 1'b0, 8'h00);
    issue({OPC_OR_REG, 1'b1, 7'h06}, 8'h06, 1'b1);
    post(8'h81, 1'b0, 1'b1, 8'h87);
  endtask : t_or
  // zero result: word in the skip cycle is dropped, flags kept
  task t_skip;
    @(posedge clk);
    vld <= 1'b1;
    instr <= {OPC_INC_SKIP, 1'b1, 7'h05};
    rdata <= 8'hff;
    @(posedge clk);
    instr <= {OPC_LOAD_LIT, 2'b00, 8'haa};
    #1;
    ck("skip", 8'h01, skip);
    ck("handled", 8'h00, hnd);
    post(8'h81, 1'b0, 1'b1, 8'h00);
    @(posedge clk);
    vld <= 1'b0;
    #1;
    ck("skip", 8'h00, skip);
    post(8'h81, 1'b0, 1'b0, 8'h00);
    issue({OPC_COPY_FILE, 1'b0, 7'h00}, 8'h00, 1'b1);
    issue({OPC_INC_SKIP, 1'b0, 7'h10}, 8'h10, 1'b1);
    ck("skip", 8'h00, skip);
    post(8'h11, 1'b1, 1'b0, 8'h00);
  endtask : t_skip
  task t_refuse;
    issue(14'h0e00, 8'h00, 1'b0);
    post(8'h11, 1'b1, 1'b0, 8'h00);
  endtask : t_refuse
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial
  begin
    #20000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    post(8'h00, 1'b0, 1'b0, 8'h00);
    ck("skip", 8'h00, skip);
    t_copy();
    t_load();
    t_inc();
    t_or();
    t_skip();
    t_refuse();
    give_verdict();
  end
endmodule : incr_or_move_instr_exec_tb
`default_nettype wire

// ==== ioxe_dec_if.sv ====
// decoded instruction fields passed from decoder to executor
`timescale 1ns/1ps
`default_nettype none
interface ioxe_dec_if;
  import ioxe_pkg::*;
  ioxe_op_e op;
  logic dest;
  logic [AW-1:0] addr;
  logic [DW-1:0] lit;
  modport dec (output op, output dest, output addr, output lit);
  modport exe (input op, input dest, input addr, input lit);
endinterface : ioxe_dec_if
`default_nettype wire

// ==== ioxe_decode.sv ====
// instruction word decoder for the handled group
`timescale 1ns/1ps
`default_nettype none
module ioxe_decode
  import ioxe_pkg::*;
(
  input wire logic [IW-1:0] instr_i, // instruction word
  ioxe_dec_if.dec dec // decoded fields
);
  always_comb
  begin
    dec.dest = instr_i[DEST_BIT];
    dec.addr = instr_i[AW-1:0];
    dec.lit = instr_i[DW-1:0];
    dec.op = OP_NONE;
    if (instr_i[LOP_HI:LOP_LO] == OPC_LOAD_LIT)
      dec.op = OP_MOVL;
    else if (instr_i[OP_HI:OP_LO] == OPC_OR_LIT)
      dec.op = OP_IORL;
    else
      unique case (instr_i[OP_HI:OP_LO])
        OPC_INC_FILE: dec.op = OP_INC;
        OPC_INC_SKIP: dec.op = OP_INCSZ;
        OPC_OR_REG: dec.op = OP_IORW;
        OPC_COPY_FILE: dec.op = OP_COPY;
        default: dec.op = OP_NONE;
      endcase
  end
endmodule : ioxe_decode
`default_nettype wire

// ==== ioxe_exec.sv ====
// execution of increment, increment-skip, or and move instructions
`timescale 1ns/1ps
`default_nettype none
module ioxe_exec
  import ioxe_pkg::*;
(
  input wire logic CLK_I, // core clock
  input wire logic RST_B_I, // sync reset, active low
  input wire logic INSTR_VALID_I, // instruction word valid
  input wire logic [ioxe_pkg::IW-1:0] INSTR_I, // instruction word
  input wire logic [ioxe_pkg::DW-1:0] FILE_RDATA_I, // addressed file data
  output logic [ioxe_pkg::AW-1:0] FILE_ADDR_O, // file register address
  output logic [ioxe_pkg::DW-1:0] FILE_WDATA_O, // file write data
  output logic FILE_WE_O, // file write strobe
  output logic [ioxe_pkg::DW-1:0] ACC_O, // accumulator
  output logic ZERO_FLAG_O, // zero flag
  output logic SKIP_O, // instruction offered in this cycle forced to no-op
  output logic HANDLED_O // valid, unskipped instruction belongs to this group
);
  import ioxe_pkg::*;

  ioxe_dec_if dec_bus ();
  logic [IW-1:0] instr_eff;
  logic skip_q, skip_d;
  logic [DW-1:0] acc_q, acc_d;
  logic zf_q, zf_d;
  logic [DW-1:0] fw_q, fw_d;
  logic fwe_q, fwe_d;
  logic [DW-1:0] result;
  logic upd_z;
  logic live;

  // skipped slot executes as a no-op
  assign live = INSTR_VALID_I && !skip_q;
  assign instr_eff = live ? INSTR_I : NOP_WORD;

  ioxe_decode u_dec (
    .instr_i(instr_eff),
    .dec(dec_bus.dec)
  );

  assign FILE_ADDR_O = dec_bus.addr;

  always_comb
  begin
    result = ZERO;
    upd_z = 1'b0;
    unique case (dec_bus.op)
      OP_INC:
      begin
        result = FILE_RDATA_I + ONE;
        upd_z = 1'b1;
      end
      OP_INCSZ: result = FILE_RDATA_I + ONE;
      OP_IORL:
      begin
        result = acc_q | dec_bus.lit;
        upd_z = 1'b1;
      end
      OP_IORW:
      begin
        result = acc_q | FILE_RDATA_I;
        upd_z = 1'b1;
      end
      OP_COPY:
      begin
        result = FILE_RDATA_I;
        upd_z = 1'b1;
      end
      OP_MOVL: result = dec_bus.lit;
      OP_NONE: result = ZERO;
    endcase
  end

  always_comb
  begin
    acc_d = acc_q;
    zf_d = zf_q;
    fw_d = fw_q;
    fwe_d = 1'b0;
    skip_d = 1'b0;
    if (upd_z)
      zf_d = (result == ZERO);
    if (dec_bus.op == OP_INCSZ)
      skip_d = (result == ZERO);
    if (dec_bus.op == OP_IORL || dec_bus.op == OP_MOVL)
      acc_d = result;
    else if (dec_bus.op != OP_NONE)
    begin
      if (dec_bus.dest)
      begin
        fw_d = result;
        fwe_d = 1'b1;
      end
      else
        acc_d = result;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      acc_q <= ZERO;
      zf_q <= 1'b0;
      fw_q <= ZERO;
      fwe_q <= 1'b0;
      skip_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      zf_q <= zf_d;
      fw_q <= fw_d;
      fwe_q <= fwe_d;
      skip_q <= skip_d;
    end
  end

  assign ACC_O = acc_q;
  assign ZERO_FLAG_O = zf_q;
  assign FILE_WDATA_O = fw_q;
  assign FILE_WE_O = fwe_q;
  assign SKIP_O = skip_q;
  assign HANDLED_O = (dec_bus.op != OP_NONE);

  sequence incsz_zero_s;
    dec_bus.op == OP_INCSZ && FILE_RDATA_I == ALL_ONES;
  endsequence

  inc_zero_flag_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    dec_bus.op == OP_INC && FILE_RDATA_I == ALL_ONES |=> zf_q)
    else $error("increment to zero did not set zero flag");
  dest_file_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    dec_bus.op == OP_INC && dec_bus.dest |=> fwe_q && fw_q == $past(FILE_RDATA_I) + ONE)
    else $error("result not written back to file");
  incsz_flags_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    dec_bus.op == OP_INCSZ |=> $stable(zf_q))
    else $error("increment-skip changed zero flag");
  skip_next_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    incsz_zero_s |=> skip_q ##0 !fwe_d ##1 !skip_q)
    else $error("zero result did not skip next instruction");
  or_lit_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    dec_bus.op == OP_IORL |=> acc_q == ($past(acc_q) | $past(dec_bus.lit)))
    else $error("literal or wrong");
  or_reg_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    dec_bus.op == OP_IORW && !dec_bus.dest |=> acc_q == ($past(acc_q) | $past(FILE_RDATA_I)))
    else $error("register or wrong");
  copy_zero_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    dec_bus.op == OP_COPY |=> zf_q == ($past(FILE_RDATA_I) == ZERO))
    else $error("copy did not test zero");
  load_lit_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    dec_bus.op == OP_MOVL |=> acc_q == $past(dec_bus.lit) && $stable(zf_q))
    else $error("literal load wrong");
  dont_care_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    live && INSTR_I[LOP_HI:LOP_LO] == OPC_LOAD_LIT |-> dec_bus.op == OP_MOVL)
    else $error("literal load not decoded");
endmodule : ioxe_exec
`default_nettype wire

// ==== ioxe_pkg.sv ====
// constants and types for the increment / or / move execution block
package ioxe_pkg;
  localparam int IW = 14;
  localparam int DW = 8;
  localparam int AW = 7;
  localparam int DEST_BIT = 7;
  localparam int OP_HI = 13;
  localparam int OP_LO = 8;
  localparam int LOP_HI = 13;
  localparam int LOP_LO = 10;
  localparam logic [5:0] OPC_INC_FILE = 6'h0a;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [5:0] OPC_OR_REG = 6'h04;
  localparam logic [5:0] OPC_COPY_FILE = 6'h08;
  localparam logic [3:0] OPC_LOAD_LIT = 4'hc;
  localparam logic [5:0] OPC_OR_LIT = 6'h38;
  localparam logic [DW-1:0] ONE = 8'h01;
  localparam logic [DW-1:0] ALL_ONES = 8'hff;
  localparam logic [DW-1:0] ZERO = 8'h00;
  localparam logic [IW-1:0] NOP_WORD = 14'h0000;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_INC = 3'b001,
    OP_INCSZ = 3'b010,
    OP_IORL = 3'b011,
    OP_IORW = 3'b100,
    OP_COPY = 3'b101,
    OP_MOVL = 3'b110
  } ioxe_op_e;
endpackage : ioxe_pkg
